// file: logic/emd_pkg.sv
// Package: register map, field layout and timing for the EMD receive config
package emd_pkg;

  // ----------------------------------------------------------------------
  // Register map (printed offsets are indices, byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] EMD_IDX_SUPP = 8'h05;
  localparam logic [7:0] EMD_IDX_SST = 8'h06;
  localparam logic [7:0] EMD_IDX_RXC1 = 8'h0B;
  localparam logic [7:0] EMD_IDX_STATUS = 8'h10;
  localparam logic [7:0] EMD_IDX_CTRL = 8'h11;

  localparam logic [7:0] EMD_SUPP_RST = 8'h00;
  localparam logic [7:0] EMD_SST_RST = 8'h00;
  localparam logic [7:0] EMD_RXC1_RST = 8'h00;
  localparam logic [7:0] EMD_CTRL_RST = 8'h00;

  // Writable bits per register; reserved bits stay zero
  localparam logic [7:0] EMD_SUPP_MASK = 8'hCF;
  localparam logic [7:0] EMD_SST_MASK = 8'h1F;
  localparam logic [7:0] EMD_RXC1_MASK = 8'hFF;
  localparam logic [7:0] EMD_CTRL_MASK = 8'h1F;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EMD_B_ENABLE = 7;
  localparam int EMD_B_RXSTART = 6;
  localparam int EMD_B_CHPICK = 7;
  // Control register bits (no-parity, no-CRC, response timer, channels)
  localparam int EMD_B_NOPAR = 0;
  localparam int EMD_B_NOCRC = 1;
  localparam int EMD_B_RESPTMR = 2;
  localparam int EMD_B_BOTHCH = 3;
  localparam int EMD_B_MANUAL = 4;

  // ----------------------------------------------------------------------
  // Timing: one etu at 106 kb/s is 128/fc, about 9440 ns
  // ----------------------------------------------------------------------
  localparam int EMD_CLK_NS = 10;
  localparam int EMD_ETU_NS = 9440;
  // Quarter etu, rounded down as a longest time
  localparam int EMD_QETU_CYC = EMD_ETU_NS / (4 * EMD_CLK_NS);

  typedef enum logic [3:0] {
    EMD_PROTO_A106 = 4'h1,
    EMD_PROTO_B106 = 4'h2,
    EMD_PROTO_OTHER = 4'h4
  } emd_proto_t;

  typedef enum logic [2:0] {
    EMD_ST_IDLE = 3'h1,
    EMD_ST_WAIT = 3'h2,
    EMD_ST_DONE = 3'h4
  } emd_state_t;

  // Filter settings toward the analog receiver
  typedef struct packed {
    logic rx_channel_pick;
    logic [2:0] lowpass_setting;
    logic zero_setting_high;
    logic zero_setting_mid_upper;
    logic zero_setting_mid_lower;
    logic zero_setting_low;
  } emd_rxcfg_t;

  // Frame events from the receive decoder
  typedef struct packed {
    logic frame_end;
    logic frame_err;
    logic [7:0] frame_len;
    logic first4_err;
    logic first4_done;
  } emd_frame_t;

  // Decisions back to the receive path
  typedef struct packed {
    logic rx_start;
    logic frame_suppress;
    logic frame_report;
    logic soft_err;
    logic restart;
  } emd_result_t;

endpackage

// file: logic/emd_suppression_rx_config.sv
// EMD suppression and receive configuration register bank with AHB-Lite
//
// Overview of operation
// - The enable bit turns EMD suppression on; clear means none is done.
// - With the start option at 0, ISO-A 106k receive start is signalled only if the first four bits are clean.
// - With the start option at 1, receive start is signalled even if the first four bits err.
// - The start option only matters for ISO-A 106k reception.
// - A frame shorter in bytes than the 4-bit threshold with errors is suppressed as EMD.
// - The 5-bit start time counts quarter etu steps from 0 to 7.75 etu; top bits reserved.
// - The start time check applies only to ISO-B at 106 kb/s.
// - Subcarrier seen sooner than the start time after the mask timer ends gives a soft error.
// - In that case with suppression on the frame is dropped and a restart is signalled.
// - With one channel enabled, the pick bit chooses AM at 0 and PM at 1.
// - With both channels and manual selection, the pick bit chooses the framing channel.
// - Low-pass and zero settings are held and driven to the analog filter.
// - The CRC skip bit at 0 checks CRC, at 1 accepts frames unchecked.
//
// Design decision made here: the AHB-Lite register port.
module emd_suppression_rx_config
  import emd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire emd_proto_t rx_proto,
  input wire emd_frame_t rx_frame,
  input wire logic crc_ok,
  input wire logic mrt_expired,
  input wire logic subcarrier_det,
  output emd_rxcfg_t rx_filter_cfg,
  output logic am_channel_en,
  output logic pm_channel_en,
  output logic framing_from_pm,
  output emd_result_t rx_result
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic [7:0] supp_reg;
  logic [7:0] sst_reg;
  logic [7:0] rxc1_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] status_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] rd_data;
  logic [7:0] addr_idx;
  logic access;

  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction

  // Writable bits of a word; zero for read-only and unmapped words
  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    if (idx == EMD_IDX_SUPP)
      write_mask = EMD_SUPP_MASK;
    else if (idx == EMD_IDX_SST)
      write_mask = EMD_SST_MASK;
    else if (idx == EMD_IDX_RXC1)
      write_mask = EMD_RXC1_MASK;
    else if (idx == EMD_IDX_CTRL)
      write_mask = EMD_CTRL_MASK;
    else
      write_mask = 8'h00;
  endfunction

  assign addr_idx = word_index(haddr);
  assign access = hsel && hready && htrans[1];
  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= access && hwrite;
      if (access)
        wr_idx_reg <= addr_idx;
    end
  end

  always_comb
  begin
    if (addr_idx == EMD_IDX_SUPP)
      rd_data = supp_reg;
    else if (addr_idx == EMD_IDX_SST)
      rd_data = sst_reg;
    else if (addr_idx == EMD_IDX_RXC1)
      rd_data = rxc1_reg;
    else if (addr_idx == EMD_IDX_CTRL)
      rd_data = ctrl_reg;
    else if (addr_idx == EMD_IDX_STATUS)
      rd_data = status_reg;
    else
      rd_data = 8'h00;
  end

  // Back-to-back read behind a write still in its data phase
  // must see the new value, not the stale register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (access && !hwrite)
    begin
      if (wr_pend_reg && (wr_idx_reg == addr_idx)
        && (addr_idx != EMD_IDX_STATUS))
        hrdata <= {24'h00_0000, hwdata[7:0] & write_mask(addr_idx)};
      else
        hrdata <= {24'h00_0000, rd_data};
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      supp_reg <= EMD_SUPP_RST;
      sst_reg <= EMD_SST_RST;
      rxc1_reg <= EMD_RXC1_RST;
      ctrl_reg <= EMD_CTRL_RST;
    end
    else if (wr_pend_reg)
    begin
      if (wr_idx_reg == EMD_IDX_SUPP)
        supp_reg <= hwdata[7:0] & EMD_SUPP_MASK;
      else if (wr_idx_reg == EMD_IDX_SST)
        sst_reg <= hwdata[7:0] & EMD_SST_MASK;
      else if (wr_idx_reg == EMD_IDX_RXC1)
        rxc1_reg <= hwdata[7:0] & EMD_RXC1_MASK;
      else if (wr_idx_reg == EMD_IDX_CTRL)
        ctrl_reg <= hwdata[7:0] & EMD_CTRL_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Receiver filter and channels
  // ----------------------------------------------------------------------
  // filter settings out
  assign rx_filter_cfg = rxc1_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      am_channel_en <= 1'b1;
      pm_channel_en <= 1'b0;
      framing_from_pm <= 1'b0;
    end
    else if (ctrl_reg[EMD_B_BOTHCH])
    begin
      am_channel_en <= 1'b1;
      pm_channel_en <= 1'b1;
      if (ctrl_reg[EMD_B_MANUAL])
        framing_from_pm <= rxc1_reg[EMD_B_CHPICK];
    end
    else
    begin
      am_channel_en <= !rxc1_reg[EMD_B_CHPICK];
      pm_channel_en <= rxc1_reg[EMD_B_CHPICK];
      framing_from_pm <= rxc1_reg[EMD_B_CHPICK];
    end
  end

  // ----------------------------------------------------------------------
  // Subcarrier start timer
  // ----------------------------------------------------------------------
  emd_state_t sst_state_reg;
  logic [9:0] qetu_cnt_reg;
  logic [5:0] qetu_steps_reg;
  logic early_sc;
  logic sst_check;
  logic mrt_prev_reg;
  logic mrt_rise;

  // Rising edge only, so a timer level held past a frame does not rearm
  assign mrt_rise = mrt_expired && !mrt_prev_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      mrt_prev_reg <= 1'b0;
    else
      mrt_prev_reg <= mrt_expired;
  end

  assign sst_check = (rx_proto == EMD_PROTO_B106);
  assign early_sc = sst_check && (sst_state_reg == EMD_ST_WAIT)
    && subcarrier_det && (qetu_steps_reg < {1'b0, sst_reg[4:0]});

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sst_state_reg <= EMD_ST_IDLE;
      qetu_cnt_reg <= 10'h000;
      qetu_steps_reg <= 6'h00;
    end
    else
    begin
      case (sst_state_reg)
        EMD_ST_IDLE:
        begin
          if (mrt_rise && sst_check)
          begin
            sst_state_reg <= EMD_ST_WAIT;
            qetu_cnt_reg <= 10'h000;
            qetu_steps_reg <= 6'h00;
          end
        end
        EMD_ST_WAIT:
        begin
          if (subcarrier_det || rx_frame.frame_end)
            sst_state_reg <= EMD_ST_DONE;
          else if (qetu_cnt_reg == 10'(EMD_QETU_CYC - 1))
          begin
            qetu_cnt_reg <= 10'h000;
            if (qetu_steps_reg != 6'h3F)
              qetu_steps_reg <= qetu_steps_reg + 6'h01;
          end
          else
            qetu_cnt_reg <= qetu_cnt_reg + 10'h001;
        end
        EMD_ST_DONE:
        begin
          if (rx_frame.frame_end || !mrt_expired)
            sst_state_reg <= EMD_ST_IDLE;
        end
        default:
          sst_state_reg <= EMD_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Frame decisions
  // ----------------------------------------------------------------------
  logic emd_on;
  logic early_seen_reg;
  logic start_ok;
  logic short_err;
  logic crc_bad;

  assign emd_on = supp_reg[EMD_B_ENABLE];

  assign start_ok = !rx_frame.first4_err || (rx_proto != EMD_PROTO_A106)
    || supp_reg[EMD_B_RXSTART];

  assign crc_bad = !ctrl_reg[EMD_B_NOCRC] && !crc_ok;

  assign short_err = emd_on && (rx_frame.frame_err || crc_bad)
    && (rx_frame.frame_len < {4'h0, supp_reg[3:0]});

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      early_seen_reg <= 1'b0;
    else if (early_sc)
      early_seen_reg <= 1'b1;
    else if (rx_frame.frame_end || sst_state_reg == EMD_ST_IDLE)
      early_seen_reg <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rx_result <= '0;
    else
    begin
      rx_result.rx_start <= rx_frame.first4_done && start_ok;
      rx_result.soft_err <= early_sc;
      rx_result.restart <= rx_frame.frame_end && emd_on
        && (early_seen_reg || short_err);
      rx_result.frame_suppress <= rx_frame.frame_end
        && (short_err || (emd_on && early_seen_reg));
      rx_result.frame_report <= rx_frame.frame_end && !short_err
        && !(emd_on && early_seen_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      status_reg <= 8'h00;
    else
      status_reg <= {4'h0, early_seen_reg, sst_state_reg};
  end

endmodule

// file: testbench/emd_card_model.sv
// Card side model: frame events toward the receive path
module emd_card_model
  import emd_pkg::*;
(
  input wire logic mclk,
  output emd_proto_t rx_proto,
  output emd_frame_t rx_frame,
  output logic crc_ok,
  output logic mrt_expired,
  output logic subcarrier_det
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_proto = EMD_PROTO_OTHER;
    rx_frame = '0;
    crc_ok = 1'b1;
    mrt_expired = 1'b0;
    subcarrier_det = 1'b0;
  end
  task automatic proto(input emd_proto_t p);
    @(posedge mclk);
    rx_proto <= p;
  endtask
  // Released lines show the inverse, not a stale value
  task automatic first4(input logic err);
    @(posedge mclk);
    rx_frame.first4_done <= 1'b1;
    rx_frame.first4_err <= err;
    @(posedge mclk);
    rx_frame.first4_done <= 1'b0;
    rx_frame.first4_err <= ~err;
  endtask
  task automatic frame(input logic [7:0] len, input logic err, crc);
    @(posedge mclk);
    rx_frame.frame_end <= 1'b1;
    rx_frame.frame_err <= err;
    rx_frame.frame_len <= len;
    crc_ok <= crc;
    @(posedge mclk);
    rx_frame.frame_end <= 1'b0;
    rx_frame.frame_err <= ~err;
    rx_frame.frame_len <= ~len;
    crc_ok <= ~crc;
    mrt_expired <= 1'b0;
  endtask
  // timer end, then subcarrier q quarter etu later
  task automatic sub(input int q);
    @(posedge mclk);
    mrt_expired <= 1'b1;
    repeat (q * EMD_QETU_CYC) @(posedge mclk);
    subcarrier_det <= 1'b1;
    @(posedge mclk);
    subcarrier_det <= 1'b0;
  endtask
endmodule

// file: testbench/emd_checker.sv
// Port checker for the EMD receive config block
module emd_checker
  import emd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire emd_proto_t rx_proto,
  input wire emd_frame_t rx_frame,
  input wire emd_rxcfg_t rx_filter_cfg,
  input wire logic am_channel_en,
  input wire logic pm_channel_en,
  input wire emd_result_t rx_result
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence f4;
    rx_frame.first4_done;
  endsequence
  bus_okay_a:
    assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rxs_clean_a:
    assert property (f4 ##0 !rx_frame.first4_err |=> rx_result.rx_start)
    else $error("no start after clean bits");
  rxs_other_a:
    assert property (f4 ##0 rx_frame.first4_err
      && rx_proto != EMD_PROTO_A106 |=> rx_result.rx_start)
    else $error("no start outside A106");
  rxs_cause_a:
    assert property (rx_result.rx_start |-> $past(rx_frame.first4_done))
    else $error("start without first bits");
  soft_b106_a:
    assert property (rx_result.soft_err |-> $past(rx_proto) == EMD_PROTO_B106)
    else $error("soft error outside B106");
  sup_restart_a:
    assert property (rx_result.frame_suppress
      |-> rx_result.restart && !rx_result.frame_report)
    else $error("suppress without restart");
  sup_cause_a:
    assert property (rx_result.frame_suppress |-> $past(rx_frame.frame_end))
    else $error("suppress without frame end");
  cfg_write_a:
    assert property (!$stable(rx_filter_cfg)
      |-> $past(hsel && hreadyout && htrans[1] && hwrite, 2))
    else $error("filter setting changed without write");
  chan_pick_a:
    assert property ((am_channel_en ^ pm_channel_en) && $stable(am_channel_en)
      && $stable(pm_channel_en) && $stable(rx_filter_cfg)
      |-> pm_channel_en == rx_filter_cfg.rx_channel_pick)
    else $error("single channel ignores pick");
endmodule
bind emd_suppression_rx_config emd_checker u_emd_checker (.mclk(mclk),
  .rst_b(rst_b), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp),
  .rx_proto(rx_proto), .rx_frame(rx_frame), .rx_filter_cfg(rx_filter_cfg),
  .am_channel_en(am_channel_en), .pm_channel_en(pm_channel_en),
  .rx_result(rx_result));

// file: testbench/test_emd_suppression_rx_config.sv
// Self-checking bench for the EMD receive config block
module test_emd_suppression_rx_config;
  import emd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] i; logic [31:0] d, e;} emd_row_t;
  logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, clr = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h0;
  logic hreadyout, hresp, crc_ok, mrt_expired, subcarrier_det;
  logic am_channel_en, pm_channel_en, framing_from_pm;
  logic [4:0] seen = '0;
  emd_proto_t rx_proto;
  emd_frame_t rx_frame;
  emd_rxcfg_t rx_filter_cfg;
  emd_result_t rx_result;
  int n_fail = 0, comparisons = 0, cyc = 0;
  emd_row_t rows[5] = '{'{EMD_IDX_SUPP, 32'hFFFFFFFF, 32'hCF},
    '{EMD_IDX_SST, 32'hFF, 32'h1F}, '{EMD_IDX_RXC1, 32'hA5, 32'hA5},
    '{EMD_IDX_CTRL, 32'hFF, 32'h1F}, '{8'h20, 32'hFF, 32'h00}};
  emd_suppression_rx_config u_emd_suppression_rx_config (.mclk(mclk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .rx_proto(rx_proto), .rx_frame(rx_frame), .crc_ok(crc_ok),
    .mrt_expired(mrt_expired), .subcarrier_det(subcarrier_det),
    .rx_filter_cfg(rx_filter_cfg), .am_channel_en(am_channel_en),
    .pm_channel_en(pm_channel_en), .framing_from_pm(framing_from_pm),
    .rx_result(rx_result));
  emd_card_model u_emd_card_model (.mclk(mclk), .rx_proto(rx_proto),
    .rx_frame(rx_frame), .crc_ok(crc_ok), .mrt_expired(mrt_expired),
    .subcarrier_det(subcarrier_det));
  always #5 mclk = ~mclk;
  // Pulses are caught here so a check never races one edge
  always @(posedge mclk) seen <= clr ? 5'h0 : seen | rx_result;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, {24'h0, d});
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic ev(input string s, input logic [4:0] e);
    repeat (3) @(posedge mclk);
    comparisons++;
    if (seen !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", s, e, seen);
    end
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    foreach (rows[k])
    begin
      xfer(1'b0, rows[k].i, 0);
      chk("reset value", 0, rd);
      xfer(1'b1, rows[k].i, rows[k].d);
      xfer(1'b0, rows[k].i, 0);
      chk("register", rows[k].e, rd);
    end
    chk("filter", 32'hA5, {24'h0, rx_filter_cfg});
    $display("test registers done");
    rst_b <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    xfer(1'b0, EMD_IDX_SUPP, 0);
    chk("mid reset", 0, rd);
    chk("mid reset pm", 0, {31'h0, pm_channel_en});
    chk("mid reset filter", 0, {24'h0, rx_filter_cfg});
    wr(EMD_IDX_RXC1, 8'h80);
    repeat (3) @(posedge mclk);
    chk("pm single", 1, {31'h0, pm_channel_en});
    wr(EMD_IDX_RXC1, 8'h00);
    repeat (3) @(posedge mclk);
    chk("am single", 1, {31'h0, am_channel_en});
    wr(EMD_IDX_CTRL, 8'h18);
    wr(EMD_IDX_RXC1, 8'h80);
    repeat (3) @(posedge mclk);
    chk("framing pm", 1, {31'h0, framing_from_pm});
    $display("test channels done");
    u_emd_card_model.proto(EMD_PROTO_A106);
    u_emd_card_model.first4(1'b1);
    ev("start bad bits", 5'h00);
    u_emd_card_model.first4(1'b0);
    ev("start clean", 5'h10);
    wr(EMD_IDX_SUPP, 8'h40);
    u_emd_card_model.first4(1'b1);
    ev("start option", 5'h10);
    wr(EMD_IDX_SUPP, 8'h00);
    u_emd_card_model.proto(EMD_PROTO_B106);
    u_emd_card_model.first4(1'b1);
    ev("start B106", 5'h10);
    $display("test start done");
    // Host keeps skip bits clear, timer bit set, threshold 4
    wr(EMD_IDX_CTRL, 8'h04);
    wr(EMD_IDX_SUPP, 8'hC4);
    u_emd_card_model.proto(EMD_PROTO_A106);
    u_emd_card_model.frame(8'h03, 1'b1, 1'b1);
    ev("short frame", 5'h09);
    u_emd_card_model.frame(8'h04, 1'b1, 1'b1);
    ev("threshold frame", 5'h04);
    u_emd_card_model.frame(8'h02, 1'b0, 1'b0);
    ev("crc short", 5'h09);
    wr(EMD_IDX_SUPP, 8'h44);
    u_emd_card_model.frame(8'h03, 1'b1, 1'b1);
    ev("off short", 5'h04);
    $display("test short frames done");
    u_emd_card_model.proto(EMD_PROTO_B106);
    wr(EMD_IDX_SST, 8'h08);
    wr(EMD_IDX_SUPP, 8'h84);
    u_emd_card_model.sub(2);
    ev("early sub", 5'h02);
    u_emd_card_model.frame(8'h0A, 1'b0, 1'b1);
    ev("early frame", 5'h09);
    wr(EMD_IDX_SUPP, 8'h04);
    u_emd_card_model.sub(2);
    ev("early off", 5'h02);
    u_emd_card_model.frame(8'h0A, 1'b0, 1'b1);
    ev("early off frame", 5'h04);
    wr(EMD_IDX_SUPP, 8'h84);
    u_emd_card_model.sub(12);
    ev("late sub", 5'h00);
    u_emd_card_model.frame(8'h0A, 1'b0, 1'b1);
    ev("late frame", 5'h04);
    u_emd_card_model.proto(EMD_PROTO_A106);
    u_emd_card_model.sub(2);
    ev("A106 sub", 5'h00);
    $display("test subcarrier done");
    end_sim();
  end
endmodule
